// ==== include/powerup_pkg.sv ====
/*
 * Shared constants and types for the enable-pin and init sequencer:
 * timing counts, device register map, own APB register map, carriers.
 * Assumes a 200 MHz system clock.
 */
package powerup_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 200000;
	localparam int CLK_MHZ = 200;
	localparam int T_READY_MS = 2;
	localparam int T_HOLD_MS = 2;
	localparam int T_TMDS_US = 1;
	localparam int READY_CYC = T_READY_MS * CLK_KHZ;
	localparam int HOLD_CYC = T_HOLD_MS * CLK_KHZ;
	localparam int TMDS_CYC = T_TMDS_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// device register map (reached over the device control bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_FILTER = 8'h16;
	localparam logic [7:0] REG_PAGE_SEL = 8'h40;
	localparam logic [7:0] REG_PAGE_OFF = 8'h41;
	localparam logic [7:0] REG_PAGE_DATA = 8'h42;
	localparam logic [7:0] REG_FC_CTL = 8'h5B;
	localparam int FC_BIT = 5;
	localparam logic [7:0] FILTER_VAL = 8'h02;
	localparam logic [7:0] PAGE_VIDEO = 8'h10;
	localparam logic [7:0] PAGE_LINK = 8'h14;
	localparam logic [7:0] PLL_CTL_OFF = 8'h49;
	localparam logic [7:0] PLL_RST_SET = 8'h10;
	localparam logic [7:0] PLL_RST_CLR = 8'h00;

	// ----------------------------------------------------------------
	// own APB register map
	// ----------------------------------------------------------------
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_UCFG0 = 12'h010;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_AUTOB = 1;
	localparam int CTRL_HRST = 2;
	localparam int CTRL_FC_LSB = 8;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam int UCFG_VALID = 16;
	localparam int NUM_UCFG = 4;
	localparam logic [16:0] UCFG_RST = 17'h00000;

	// ----------------------------------------------------------------
	// sequence step indices
	// ----------------------------------------------------------------
	localparam logic [2:0] A_FIXED = 3'h2;
	localparam logic [2:0] A_LAST = 3'h5;
	localparam logic [2:0] B_LAST = 3'h7;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_PREP = 3'b000,
		ST_OFF = 3'b001,
		ST_READY = 3'b010,
		ST_INITA = 3'b011,
		ST_WAITT = 3'b100,
		ST_INITB = 3'b101,
		ST_RUN = 3'b110
	} seq_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} devwr_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage : powerup_pkg

// ==== hdl/hold_timer.sv ====
/*
 * Loadable down-counter; expired is high while the count sits at zero.
 * Assumes load and loadVal come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module hold_timer #(
	parameter int CNT_W = 20
) (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic load, // restart the count
	input wire logic [CNT_W-1:0] loadVal, // cycles to count
	output logic expired // count has reached zero
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} tmr_state_t;

	tmr_state_t s_r;
	tmr_state_t s_nxt;

	generate
		if (CNT_W < 2 || CNT_W > 31) begin : g_bad_width
			$error("hold_timer: CNT_W out of range");
		end
	endgenerate

	always_comb begin
		s_nxt = s_r;
		if (load) begin
			s_nxt.cnt = loadVal;
		end else if (s_r.cnt != '0) begin
			s_nxt.cnt = s_r.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign expired = (s_r.cnt == '0);

endmodule : hold_timer

`default_nettype wire

// ==== hdl/powerup_init_ctrl.sv ====
/*
 * Host-side controller for a video-to-serial-link bridge: drives the
 * active-high enable pin, waits for the control bus, runs the two
 * initialisation sequences as device register writes, and takes its
 * orders over APB. Assumes an external bus engine on the same clock that
 * carries each devWr word to the device and pulses devWrAck when done.
 */
// What this block does
// R1: enable pin driven from logic, not RC
// R2: no device access until 2 ms after enable
// R3: enable held low at least 2 ms
// R4: release enable only after supplies are stable
// R5: drive video input only after enable
// R6: first sequence clears bit 5 of 0x5B
// R7: first sequence writes 0x02 to 0x16
// R8: second sequence only after TMDS clock stable
// R9: pulse video-input PLL reset via page 0x10
// R10: then pulse serial-link PLL reset via page 0x14
// R11: 0x40/0x41/0x42 form the paged window
// R12: page 0x10 offset 0x49 bit 4 resets
// R13: page 0x14 offset 0x49 bit 4 resets
// R14: TMDS clock stable 1 us before resets
// R15: first sequence before second, redo after reset
`timescale 1ns/1ps
`default_nettype none

module powerup_init_ctrl
	import powerup_pkg::*;
#(
	parameter int CNT_W = 20,
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int READY_CYCLES = READY_CYC
) (
	input wire logic clk, // 200 MHz system clock
	input wire logic reset, // synchronous, active high
	input wire apb_req_t apbIn, // APB request from software
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready, zero wait
	output logic pslverr, // APB error on unmapped address
	input wire logic suppliesGood, // pin: all supplies settled
	input wire logic tmdsClkStable, // pin: TMDS clock on target
	output logic chipEnablePin, // device enable, active high
	output logic videoInputEnable, // allow video source to drive
	output logic devWrReq, // device write request
	output devwr_t devWr, // device register address and data
	input wire logic devWrAck // device write finished, one pulse
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_state_t st;
		logic supS1;
		logic supS2;
		logic tmdS1;
		logic tmdS2;
		logic chipEn;
		logic vidEn;
		logic req;
		devwr_t wr;
		logic [2:0] idx;
		logic doneA;
		logic doneB;
		logic [15:0] ctrl;
		logic [NUM_UCFG-1:0][16:0] ucfg;
		logic [31:0] prdata;
		logic slverr;
	} ctl_state_t;

	ctl_state_t s_r;
	ctl_state_t s_nxt;
	logic loadT;
	logic [CNT_W-1:0] loadVal;
	logic expired;
	devwr_t cur;
	logic skip;
	logic hit;
	logic apbAccess;

	generate
		if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (2 ** CNT_W) ||
			READY_CYCLES < 1 || READY_CYCLES >= (2 ** CNT_W) ||
			TMDS_CYC >= (2 ** CNT_W)) begin : g_bad_count
			$error("powerup_init_ctrl: count does not fit CNT_W");
		end
	endgenerate

	// ----------------------------------------------------------------
	// step tables
	// ----------------------------------------------------------------
	// second sequence: idx[2] picks the PLL, idx[1:0] the window step
	function automatic devwr_t bWrite(input logic [2:0] i);
		devwr_t w;
		w.addr = REG_PAGE_DATA;
		w.data = PLL_RST_CLR;
		case (i[1:0])
			2'h0: begin
				w.addr = REG_PAGE_SEL;
				w.data = i[2] ? PAGE_LINK : PAGE_VIDEO; // R9 R10 R11
			end
			2'h1: begin
				w.addr = REG_PAGE_OFF;
				w.data = PLL_CTL_OFF; // R12 R13
			end
			2'h2: w.data = PLL_RST_SET; // R12 R13
			default: w.data = PLL_RST_CLR; // R9 R10
		endcase
		return w;
	endfunction : bWrite

	function automatic devwr_t aWrite(input logic [2:0] i,
		input logic [7:0] fcBase, input logic [16:0] u);
		devwr_t w;
		w.addr = u[15:8];
		w.data = u[7:0];
		if (i == 3'h0) begin
			w.addr = REG_FC_CTL;
			w.data = fcBase & ~(8'h01 << FC_BIT); // R6
		end else if (i == 3'h1) begin
			w.addr = REG_FILTER;
			w.data = FILTER_VAL; // R7
		end
		return w;
	endfunction : aWrite

	hold_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.clk(clk),
		.reset(reset),
		.load(loadT),
		.loadVal(loadVal),
		.expired(expired)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] ui;
		logic [2:0] ai;
		ui = 2'h0;
		ai = 3'h0;
		s_nxt = s_r;
		s_nxt.supS1 = suppliesGood;
		s_nxt.supS2 = s_r.supS1;
		s_nxt.tmdS1 = tmdsClkStable;
		s_nxt.tmdS2 = s_r.tmdS1;
		s_nxt.ctrl[CTRL_HRST] = 1'b0;
		loadT = 1'b0;
		loadVal = CNT_W'(HOLD_CYCLES);
		// user entries follow the two fixed writes of the first sequence
		ai = s_r.idx - A_FIXED;
		cur = (s_r.st == ST_INITB) ? bWrite(s_r.idx) :
			aWrite(s_r.idx, s_r.ctrl[CTRL_FC_LSB +: 8], s_r.ucfg[ai[1:0]]);
		skip = (s_r.st == ST_INITA) && (s_r.idx >= A_FIXED) &&
			!s_r.ucfg[ai[1:0]][UCFG_VALID];

		// apb slave: read data is captured in the setup cycle
		apbAccess = apbIn.psel && apbIn.penable;
		hit = (apbIn.paddr == A_CTRL) || (apbIn.paddr == A_STATUS) ||
			(apbIn.paddr[11:4] == A_UCFG0[11:4] && apbIn.paddr[1:0] == 2'h0);
		ui = apbIn.paddr[3:2];
		if (apbIn.psel && !apbIn.penable) begin
			s_nxt.slverr = !hit;
			s_nxt.prdata = 32'h0000_0000;
			if (apbIn.paddr == A_CTRL) begin
				s_nxt.prdata = {16'h0000, s_r.ctrl};
			end else if (apbIn.paddr == A_STATUS) begin
				s_nxt.prdata = {20'h00000, s_r.tmdS2, s_r.supS2, s_r.vidEn,
					s_r.chipEn, s_r.doneB, s_r.doneA, s_r.req, s_r.st,
					2'h0};
			end else if (hit) begin
				s_nxt.prdata = {15'h0000, s_r.ucfg[ui]};
			end
		end
		if (apbAccess && apbIn.pwrite) begin
			if (apbIn.paddr == A_CTRL) begin
				s_nxt.ctrl = apbIn.pwdata[15:0];
			end else if (hit && apbIn.paddr != A_STATUS) begin
				s_nxt.ucfg[ui] = apbIn.pwdata[16:0];
			end
		end

		// sequencer
		case (s_r.st)
			ST_PREP: begin
				loadT = 1'b1;
				loadVal = CNT_W'(HOLD_CYCLES); // R3
				s_nxt.st = ST_OFF;
			end
			ST_OFF: begin
				// release only after the low hold and with supplies good
				if (expired && s_r.supS2 && s_r.ctrl[CTRL_RUN]) begin // R3 R4
					s_nxt.chipEn = 1'b1; // R1
					s_nxt.st = ST_READY;
					loadT = 1'b1;
					loadVal = CNT_W'(READY_CYCLES); // R2
				end
			end
			ST_READY: begin
				if (expired) begin // R2
					s_nxt.st = ST_INITA;
					s_nxt.idx = 3'h0;
					s_nxt.vidEn = 1'b1; // R5
				end
			end
			ST_INITA, ST_INITB: begin
				if (!s_r.req && skip) begin
					s_nxt.idx = s_r.idx + 3'h1;
				end else if (!s_r.req) begin
					s_nxt.req = 1'b1;
					s_nxt.wr = cur;
				end else if (devWrAck) begin
					s_nxt.req = 1'b0;
					s_nxt.idx = s_r.idx + 3'h1;
				end
				if ((!s_r.req && skip) || (s_r.req && devWrAck)) begin
					if (s_r.st == ST_INITA && s_r.idx == A_LAST) begin // R15
						s_nxt.st = ST_WAITT;
						s_nxt.doneA = 1'b1;
						loadT = 1'b1;
						loadVal = CNT_W'(TMDS_CYC);
					end else if (s_r.st == ST_INITB && s_r.idx == B_LAST) begin
						s_nxt.st = ST_RUN;
						s_nxt.doneB = 1'b1;
					end
				end
			end
			ST_WAITT: begin
				// any drop of the stable flag restarts the window
				if (!s_r.tmdS2) begin // R8 R14
					loadT = 1'b1;
					loadVal = CNT_W'(TMDS_CYC);
				end else if (expired && s_r.ctrl[CTRL_AUTOB]) begin // R8 R14
					s_nxt.st = ST_INITB;
					s_nxt.idx = 3'h0;
				end
			end
			ST_RUN: begin
				s_nxt.st = ST_RUN;
			end
			default: begin
				s_nxt.st = ST_PREP;
			end
		endcase

		// hard reset, power-down or supply loss: back to a full low hold
		if (s_r.ctrl[CTRL_HRST] ||
			(s_r.chipEn && (!s_r.supS2 || !s_r.ctrl[CTRL_RUN]))) begin // R3 R15
			s_nxt.st = ST_PREP;
			s_nxt.chipEn = 1'b0;
			s_nxt.vidEn = 1'b0; // R5
			s_nxt.req = 1'b0;
			s_nxt.doneA = 1'b0;
			s_nxt.doneB = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.st <= ST_PREP;
			s_r.ctrl <= CTRL_RST;
			s_r.ucfg <= {NUM_UCFG{UCFG_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = 1'b1;
	assign pslverr = s_r.slverr && apbIn.psel && apbIn.penable;
	assign chipEnablePin = s_r.chipEn;
	assign videoInputEnable = s_r.vidEn;
	assign devWrReq = s_r.req;
	assign devWr = s_r.wr;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] lowCnt;
	logic [CNT_W-1:0] highCnt;
	logic [CNT_W-1:0] stCnt;
	logic inB;

	assign inB = (s_r.st == ST_INITB);

	always_ff @(posedge clk) begin
		if (reset) begin
			lowCnt <= '0;
			highCnt <= '0;
			stCnt <= '0;
		end else begin
			lowCnt <= (s_r.chipEn || &lowCnt) ? (s_r.chipEn ? '0 : lowCnt) :
				lowCnt + {{(CNT_W-1){1'b0}}, 1'b1};
			highCnt <= (!s_r.chipEn || &highCnt) ?
				(s_r.chipEn ? highCnt : '0) :
				highCnt + {{(CNT_W-1){1'b0}}, 1'b1};
			stCnt <= (!s_r.tmdS2 || &stCnt) ? (s_r.tmdS2 ? stCnt : '0) :
				stCnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	chk_low_hold: assert property (@(posedge clk) disable iff (reset) // R3
		$rose(chipEnablePin) |-> lowCnt >= CNT_W'(HOLD_CYCLES))
		else $error("enable released before the low hold ended");

	chk_bus_ready: assert property (@(posedge clk) disable iff (reset) // R2
		$rose(devWrReq) |-> highCnt >= CNT_W'(READY_CYCLES))
		else $error("device access before bus ready time");

	chk_supply_release: assert property (@(posedge clk) // R4
		disable iff (reset)
		$rose(chipEnablePin) |-> $past(s_r.supS2) && s_r.supS2)
		else $error("enable released without supplies good");

	chk_video_after: assert property (@(posedge clk) disable iff (reset) // R5
		videoInputEnable |-> chipEnablePin && $past(chipEnablePin))
		else $error("video enabled while device disabled");

	chk_fc_bit: assert property (@(posedge clk) disable iff (reset) // R6
		devWrReq && devWr.addr == REG_FC_CTL |-> !devWr.data[FC_BIT])
		else $error("frequency-change reset bit not cleared");

	chk_filter_value: assert property (@(posedge clk) // R7
		disable iff (reset)
		devWrReq && !inB && s_r.idx == 3'h1 |->
			devWr.addr == REG_FILTER && devWr.data == FILTER_VAL)
		else $error("wrong bus event filter write");

	chk_tmds_window: assert property (@(posedge clk) disable iff (reset) // R14
		$rose(inB) |-> $past(stCnt) >= CNT_W'(TMDS_CYC) && s_r.doneA)
		else $error("PLL resets started before TMDS stable window");

	chk_pll_pulse: assert property (@(posedge clk) // R9
		disable iff (reset)
		devWrReq && inB && devWr.addr == REG_PAGE_DATA &&
			devWr.data == PLL_RST_SET && devWrAck
		|=> ##1 devWrReq && devWr.addr == REG_PAGE_DATA &&
			devWr.data == PLL_RST_CLR)
		else $error("PLL reset set not followed by clear");

	chk_page_order: assert property (@(posedge clk) // R10
		disable iff (reset)
		devWrReq && inB && devWr.addr == REG_PAGE_SEL |->
			(devWr.data == PAGE_VIDEO && s_r.idx == 3'h0) ||
			(devWr.data == PAGE_LINK && s_r.idx == 3'h4))
		else $error("wrong page selected for PLL reset");

	chk_req_hold: assert property (@(posedge clk) disable iff (reset) // write request held until ack
		devWrReq && !devWrAck && $past(s_r.st) == s_r.st |=>
			(devWrReq && $stable(devWr)) || !chipEnablePin)
		else $error("device write request dropped or changed early");

endmodule : powerup_init_ctrl

`default_nettype wire

// ==== sim/dev_model.sv ====
/*
 * Behavioural model of the bridge device behind the control bus: byte
 * register file, paged window, PLL reset bits and enable-pin timing.
 * Assumes the controller's write handshake runs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dev_model
	import powerup_pkg::*;
#(
	parameter int READY = 50, // cycles from enable to bus ready
	parameter int HOLD = 50 // low cycles that cause a hard reset
) (
	input wire logic clk, // system clock
	input wire logic enablePin, // chip enable, active high
	input wire logic wrReq, // write request
	input wire devwr_t wr, // address and data
	input wire logic [3:0] lag, // extra cycles before ack
	output logic ack // one-cycle write done
);
	logic [7:0] regs [256];
	logic [1:0] pllRst = 2'b00;
	devwr_t wlog [$];
	int onCnt = 0, offCnt = 0, waitCnt = 0, idx = 0;
	int early = 0, badBits = 0, hardResets = 0;
	int pulses [2] = '{0, 0};

	initial ack = 1'b0;

	always @(posedge clk) begin
		ack <= 1'b0;
		onCnt <= enablePin ? onCnt + 1 : 0;
		offCnt <= enablePin ? 0 : offCnt + 1;
		if (!enablePin && offCnt == HOLD - 1) begin
			hardResets <= hardResets + 1;
			pllRst <= 2'b00;
		end
		// a bus that is not ready yet never answers
		if (wrReq && !ack && enablePin) begin
			if (onCnt < READY) begin
				early <= early + 1;
			end else if (waitCnt < lag) begin
				waitCnt <= waitCnt + 1;
			end else begin
				ack <= 1'b1;
				waitCnt <= 0;
				wlog.push_back(wr);
				regs[wr.addr] <= wr.data;
				if (wr.addr == REG_PAGE_DATA && regs[REG_PAGE_OFF] == PLL_CTL_OFF
						&& (regs[REG_PAGE_SEL] == PAGE_VIDEO
						|| regs[REG_PAGE_SEL] == PAGE_LINK)) begin
					idx = (regs[REG_PAGE_SEL] == PAGE_LINK) ? 1 : 0;
					if (wr.data[4] && !pllRst[idx]) begin
						pulses[idx] <= pulses[idx] + 1;
					end
					pllRst[idx] <= wr.data[4];
					if (wr.data[3:0] != 4'h0) begin
						badBits <= badBits + 1;
					end
				end
			end
		end
	end
endmodule : dev_model

`default_nettype wire

// ==== sim/tb.sv ====
/*
 * Self-checking bench for the enable and init sequencer with the device
 * model on its write link. Assumes shortened hold and ready counts.
 */
`timescale 1ns/1ps
`default_nettype none

module tb
	import powerup_pkg::*;
();
	localparam int HOLD = 50;
	localparam int READY = 50;
	logic clk = 1'b0;
	logic reset = 1'b1;
	apb_req_t apbIn = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, chipEnablePin, videoInputEnable, devWrReq, rdErr;
	logic devWrAck;
	logic suppliesGood = 1'b0, tmdsClkStable = 1'b0, enPrev = 1'b0;
	logic reqPrev = 1'b0;
	logic [3:0] lag = 4'h0;
	devwr_t devWr;
	devwr_t expQ [$];
	devwr_t seqB [8] = '{
		'{REG_PAGE_SEL, PAGE_VIDEO}, '{REG_PAGE_OFF, PLL_CTL_OFF},
		'{REG_PAGE_DATA, PLL_RST_SET}, '{REG_PAGE_DATA, PLL_RST_CLR},
		'{REG_PAGE_SEL, PAGE_LINK}, '{REG_PAGE_OFF, PLL_CTL_OFF},
		'{REG_PAGE_DATA, PLL_RST_SET}, '{REG_PAGE_DATA, PLL_RST_CLR}};
	int reqTimes [$];
	int nFail = 0, checks = 0, cyc = 0, enRise = 0, enFall = 0, badVid = 0;

	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		enPrev <= chipEnablePin;
		reqPrev <= devWrReq;
		if (chipEnablePin && !enPrev) enRise <= cyc;
		if (!chipEnablePin && enPrev) enFall <= cyc;
		if (devWrReq && !reqPrev) reqTimes.push_back(cyc);
		if (videoInputEnable === 1'b1 && chipEnablePin !== 1'b1) begin
			badVid <= badVid + 1;
		end
	end

	powerup_init_ctrl #(.HOLD_CYCLES(HOLD), .READY_CYCLES(READY)) DUT (.clk,
		.reset, .apbIn, .prdata, .pready, .pslverr, .suppliesGood,
		.tmdsClkStable, .chipEnablePin, .videoInputEnable, .devWrReq, .devWr,
		.devWrAck);

	dev_model #(.READY(READY), .HOLD(HOLD)) devModel (.clk,
		.enablePin(chipEnablePin), .wrReq(devWrReq), .wr(devWr), .lag,
		.ack(devWrAck));

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			nFail++;
		end
	endtask : chk

	// one idle cycle after each transfer, so psel never toggles in a step
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		apbIn <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apbIn.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		rdErr = pslverr;
		apbIn <= '0;
		@(posedge clk);
	endtask : apb

	task automatic wait_status(input int b, input string nm);
		for (int n = 0; n < 3000; n++) begin
			apb(1'b0, A_STATUS, 32'h0);
			if (rd[b] === 1'b1) break;
		end
		chk(nm, 32'h1, {31'h0, rd[b]});
	endtask : wait_status

	task automatic cmp_log(input int base, input logic withB);
		expQ = {};
		expQ.push_back(devwr_t'{REG_FC_CTL, 8'hFF & ~(8'h01 << FC_BIT)});
		expQ.push_back(devwr_t'{REG_FILTER, FILTER_VAL});
		expQ.push_back(devwr_t'{8'h30, 8'hA5});
		if (withB) foreach (seqB[i]) expQ.push_back(seqB[i]);
		chk("write count", expQ.size(), devModel.wlog.size() - base);
		foreach (expQ[i]) chk("device write", expQ[i], devModel.wlog[base + i]);
	endtask : cmp_log

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		chk("enable after reset", 32'h0, chipEnablePin);
		apb(1'b0, A_CTRL, 32'h0);
		chk("control reset", 32'h0, rd);
		apb(1'b1, 12'h020, 32'hFFFFFFFF);
		chk("unmapped error", 32'h1, rdErr);
		$display("test reset done");
	endtask : t_reset

	task automatic t_power();
		int t0;
		apb(1'b1, A_UCFG0, 32'h000130A5);
		apb(1'b1, A_UCFG0 + 12'h004, 32'h000031A6);
		apb(1'b1, A_CTRL, 32'h0000FF01);
		repeat (200) @(posedge clk);
		chk("enable before supplies", 32'h0, chipEnablePin);
		t0 = cyc;
		suppliesGood <= 1'b1;
		wait_status(6, "first sequence done");
		chk("hold and release", 32'h1, enRise > t0 && enRise >= HOLD + 16);
		chk("ready wait", 32'h1, reqTimes[0] - enRise >= READY);
		cmp_log(0, 1'b0);
		apb(1'b1, A_CTRL, 32'h0000FF03);
		repeat (100) @(posedge clk);
		chk("no writes before clock stable", 32'h3, devModel.wlog.size());
		tmdsClkStable <= 1'b1;
		repeat (100) @(posedge clk);
		tmdsClkStable <= 1'b0;
		@(posedge clk);
		t0 = cyc;
		tmdsClkStable <= 1'b1;
		wait_status(7, "second sequence done");
		chk("stable window", 32'h1, reqTimes[3] - t0 >= TMDS_CYC);
		cmp_log(0, 1'b1);
		chk("video pll pulses", 32'h1, devModel.pulses[0]);
		chk("link pll pulses", 32'h1, devModel.pulses[1]);
		chk("pll bits end clear", 32'h0, devModel.pllRst);
		$display("test power-up done");
	endtask : t_power

	task automatic t_hard();
		int base, h0;
		base = devModel.wlog.size();
		h0 = devModel.hardResets;
		lag <= 4'h3;
		apb(1'b1, A_CTRL, 32'h0000FF07);
		// the enable falls at the edge that ends the idle cycle of apb
		@(posedge clk);
		chk("enable dropped", 32'h0, chipEnablePin);
		wait_status(7, "redo done");
		chk("low pulse width", 32'h1, enRise - enFall >= HOLD);
		chk("device hard reset", h0 + 1, devModel.hardResets);
		cmp_log(base, 1'b1);
		apb(1'b0, A_CTRL, 32'h0);
		chk("reset bit clears", 32'h0000FF03, rd);
		$display("test hard reset done");
	endtask : t_hard

	task automatic t_supply();
		suppliesGood <= 1'b0;
		repeat (4) @(posedge clk);
		chk("enable on supply loss", 32'h0, chipEnablePin);
		chk("video off", 32'h0, videoInputEnable);
		suppliesGood <= 1'b1;
		wait_status(7, "recovery done");
		chk("early accesses", 32'h0, devModel.early);
		chk("reserved bits", 32'h0, devModel.badBits);
		chk("video before enable", 32'h0, badVid);
		apb(1'b1, A_CTRL, 32'h0000FF02);
		@(posedge clk);
		chk("enable on power-down", 32'h0, chipEnablePin);
		chk("video on power-down", 32'h0, videoInputEnable);
		$display("test supply loss done");
	endtask : t_supply

	task automatic finishTest();
		$display("checks %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finishTest

	initial begin
		#200000;
		nFail++;
		finishTest();
	end

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_power();
		t_hard();
		t_supply();
		finishTest();
	end
endmodule : tb

`default_nettype wire
